/* File: pll_params.svh */
// Purpose: Shared offsets, field positions, reset values and timing counts for the loop control pair.
// Assumes: CLK at 40 MHz on both ends.
// Notes on behaviour
// (RULE_01) Phase fixed at configuration or stepped live
// (RULE_02) Feedback phase step may drop lock; wait
// (RULE_03) Reference chosen live from two sources
// (RULE_04) Bus port rewrites loop settings and dividers
// (RULE_05) User side must include the bus bridge
// (RULE_06) Settings rewrite may drop lock; wait
// (RULE_07) User drives two-bit output select
// (RULE_08) User drives step direction
// (RULE_09) One toggle moves phase one increment
// (RULE_10) Select and direction steady around toggle
// (RULE_11) Lock compares reference against feedback clock
`ifndef PLL_PARAMS_SVH
`define PLL_PARAMS_SVH

`define CLK_FREQ_MHZ 40
`define LOCK_TIME_NS 15000
`define LOCK_CYCLES ((`LOCK_TIME_NS * `CLK_FREQ_MHZ + 999) / 1000)
`define LOCK_WINDOW_CYCLES 64

// Loop settings words, byte addressed on the bus port
`define CFG_REF_DIV 8'h00
`define CFG_FB_DIV 8'h01
`define CFG_OUT_DIV 8'h02
`define CFG_CTRL 8'h03
`define CTRL_DYN_BIT 0
`define CTRL_FBSEL_LSB 1
`define DIV_RESET 8'h01
`define CTRL_RESET 8'h01
`define PHASE_RESET 8'h00

// Controller registers, byte addresses
`define REG_PHASE_CMD 8'h00
`define REG_REF_SEL 8'h04
`define REG_CFG_CMD 8'h08
`define REG_STATUS 8'h0C
`define REG_INT_STATUS 8'h10
`define REG_INT_MASK 8'h14
`define CMD_SEL_LSB 0
`define CMD_DIR_BIT 2
`define CMD_COUNT_LSB 8
`define CFG_DATA_LSB 0
`define CFG_ADDR_LSB 8
`define CFG_READ_BIT 16
`define INT_STEP_DONE 0
`define INT_CFG_DONE 1
`define INT_LOCK_LOST 2
`define INT_STABLE 3

`endif

/* File: pll_pkg.sv */
// Purpose: Types shared by the loop end and the user controller.
// Assumes: Nothing beyond the parameter header.
// Notes: State of each module is one packed struct.
package pll_pkg;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SETUP,
    ST_TOGGLE,
    ST_GAP,
    ST_BUS,
    ST_SETTLE
  } ctl_state_t;

  typedef struct packed {
    logic [2:0] ref_a_sync;
    logic [2:0] ref_b_sync;
    logic [2:0] fb_sync;
    logic step_prev;
    logic refsel_prev;
    logic [3:0][7:0] phase;
    logic [7:0] ref_div;
    logic [7:0] fb_div;
    logic [7:0] out_div;
    logic [7:0] ctrl;
    logic ack;
    logic [7:0] rdata;
    logic locked;
    logic [15:0] settle;
    logic [15:0] win;
    logic [15:0] ref_cnt;
    logic [15:0] fb_cnt;
  } loop_state_t;

  typedef struct packed {
    ctl_state_t state;
    logic [1:0] sel;
    logic dir;
    logic step;
    logic [3:0] count;
    logic refsel;
    logic cyc;
    logic we;
    logic [7:0] adr;
    logic [7:0] dat;
    logic [7:0] bus_rdata;
    logic [31:0] rd;
    logic [3:0] int_st;
    logic [3:0] int_mask;
    logic irq;
    logic [15:0] settle;
    logic stable;
    logic lock_prev;
  } ctl_state_str_t;

endpackage : pll_pkg

/* File: pll_link_if.sv */
// Purpose: Joins the loop end and the user controller.
// Assumes: Both ends on the same CLK.
// Notes: Bus part is classic single-cycle WISHBONE.
`timescale 1ns/1ps
interface pll_link_if;
  logic [1:0] phase_output_select;
  logic phase_step_direction;
  logic phase_step_toggle;
  logic reference_source_selector;
  logic wb_cyc;
  logic wb_stb;
  logic wb_we;
  logic [7:0] wb_adr;
  logic [7:0] wb_dat_w;
  logic [7:0] wb_dat_r;
  logic wb_ack;
  logic lock;

  modport loop (
    input phase_output_select, phase_step_direction, phase_step_toggle, reference_source_selector,
    input wb_cyc, wb_stb, wb_we, wb_adr, wb_dat_w,
    output wb_dat_r, wb_ack, lock
  );

  modport user (
    output phase_output_select, phase_step_direction, phase_step_toggle, reference_source_selector,
    output wb_cyc, wb_stb, wb_we, wb_adr, wb_dat_w,
    input wb_dat_r, wb_ack, lock
  );
endinterface : pll_link_if

/* File: pll_loop_end.sv */
// Purpose: Digital control around the phase-locked loop: phase steps, reference choice, settings port, lock.
// Assumes: Reference and feedback clocks are slow against CLK and arrive asynchronously.
// Notes: Feedback is compared edge for edge against the chosen reference, unscaled.
//
// The plain strobed port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`include "pll_params.svh"
module pll_loop_end #(
  parameter int LOCK_CYCLES = `LOCK_CYCLES,
  parameter int WIN_CYCLES = `LOCK_WINDOW_CYCLES
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic LOOP_REFERENCE_IN_A,
  input wire logic LOOP_REFERENCE_IN_B,
  input wire logic LOOP_FEEDBACK_IN,
  pll_link_if.loop link,
  output logic LOCKED,
  output logic REF_SOURCE,
  output logic [31:0] PHASE_OFFSETS,
  output logic [7:0] REF_DIVIDER,
  output logic [7:0] FB_DIVIDER,
  output logic [7:0] OUT_DIVIDER
);

  if (LOCK_CYCLES < 1 || LOCK_CYCLES > 65535) begin : g_chk_lock
    $error("LOCK_CYCLES outside 1..65535");
  end
  if (WIN_CYCLES < 2 || WIN_CYCLES > 65535) begin : g_chk_win
    $error("WIN_CYCLES outside 2..65535");
  end

  localparam logic [15:0] LOCK_LOAD = 16'(LOCK_CYCLES);
  localparam logic [15:0] WIN_LOAD = 16'(WIN_CYCLES - 1);

  pll_pkg::loop_state_t s_q;
  pll_pkg::loop_state_t s_d;

  function automatic logic counts_match(input logic [15:0] a, input logic [15:0] b);
    logic [15:0] diff;
    diff = (a > b) ? (a - b) : (b - a);
    counts_match = (a != 16'h0000) && (diff <= 16'h0001);
  endfunction : counts_match

  function automatic logic rose(input logic [2:0] sync);
    rose = sync[1] & ~sync[2];
  endfunction : rose

  logic ref_edge;
  logic fb_edge;
  logic step_seen;
  logic fb_output_stepped;
  logic bus_take;
  logic cfg_write;
  logic ref_switched;
  logic lose_lock;
  logic [7:0] cfg_read;

  always_comb begin
    s_d = s_q;
    // Two flops before use; third flop only for the edge
    s_d.ref_a_sync = {s_q.ref_a_sync[1:0], LOOP_REFERENCE_IN_A};
    s_d.ref_b_sync = {s_q.ref_b_sync[1:0], LOOP_REFERENCE_IN_B};
    s_d.fb_sync = {s_q.fb_sync[1:0], LOOP_FEEDBACK_IN};

    // Reference taken from whichever source is selected now
    ref_edge = link.reference_source_selector ? rose(s_q.ref_b_sync) : rose(s_q.ref_a_sync); // RULE_03
    fb_edge = rose(s_q.fb_sync);
    ref_switched = link.reference_source_selector != s_q.refsel_prev;
    s_d.refsel_prev = link.reference_source_selector;

    // Any edge of the toggle is one step
    step_seen = link.phase_step_toggle != s_q.step_prev;
    s_d.step_prev = link.phase_step_toggle;
    fb_output_stepped = 1'b0;
    if (s_q.ctrl[`CTRL_DYN_BIT]) begin
      if (step_seen) begin
        if (link.phase_step_direction) begin
          s_d.phase[link.phase_output_select] = s_q.phase[link.phase_output_select] + 8'h01; // RULE_09
        end else begin
          s_d.phase[link.phase_output_select] = s_q.phase[link.phase_output_select] - 8'h01; // RULE_09
        end
        fb_output_stepped = link.phase_output_select == s_q.ctrl[`CTRL_FBSEL_LSB +: 2];
      end
    end else begin
      // Static mode forces every offset back to PHASE_RESET; steps are ignored
      s_d.phase = {4{`PHASE_RESET}}; // RULE_01
    end

    // Classic slave: one ack per strobe, never waits more than a cycle
    bus_take = link.wb_cyc & link.wb_stb & ~s_q.ack;
    s_d.ack = bus_take;
    cfg_write = bus_take & link.wb_we;
    case (link.wb_adr)
      `CFG_REF_DIV: cfg_read = s_q.ref_div;
      `CFG_FB_DIV: cfg_read = s_q.fb_div;
      `CFG_OUT_DIV: cfg_read = s_q.out_div;
      `CFG_CTRL: cfg_read = s_q.ctrl;
      default: cfg_read = 8'h00;
    endcase
    if (bus_take) begin
      s_d.rdata = link.wb_we ? 8'h00 : cfg_read;
    end
    if (cfg_write) begin
      case (link.wb_adr)
        `CFG_REF_DIV: s_d.ref_div = link.wb_dat_w; // RULE_04
        `CFG_FB_DIV: s_d.fb_div = link.wb_dat_w; // RULE_04
        `CFG_OUT_DIV: s_d.out_div = link.wb_dat_w; // RULE_04
        `CFG_CTRL: s_d.ctrl = link.wb_dat_w; // RULE_04
        default: s_d.ctrl = s_q.ctrl;
      endcase
    end

    // Settings rewrite, feedback phase step or source change restart the lock wait
    lose_lock = fb_output_stepped | cfg_write | ref_switched; // RULE_02 RULE_06

    // Edge counts over a fixed window decide frequency match
    s_d.ref_cnt = s_q.ref_cnt + {15'h0000, ref_edge}; // RULE_11
    s_d.fb_cnt = s_q.fb_cnt + {15'h0000, fb_edge}; // RULE_11
    s_d.win = s_q.win - 16'h0001;
    if (s_q.settle != 16'h0000) begin
      s_d.settle = s_q.settle - 16'h0001;
    end
    if (s_q.win == 16'h0000) begin
      s_d.win = WIN_LOAD;
      s_d.ref_cnt = 16'h0000;
      s_d.fb_cnt = 16'h0000;
      if (counts_match(s_q.ref_cnt, s_q.fb_cnt)) begin
        s_d.locked = s_q.settle == 16'h0000; // RULE_11
      end else begin
        s_d.locked = 1'b0;
      end
    end
    if (lose_lock) begin
      // Restart the window too, so stale edges cannot vouch for the new setting
      s_d.locked = 1'b0; // RULE_02 RULE_06
      s_d.settle = LOCK_LOAD; // RULE_06
      s_d.win = WIN_LOAD;
      s_d.ref_cnt = 16'h0000;
      s_d.fb_cnt = 16'h0000;
    end

    if (RST) begin
      s_d = '0;
      s_d.phase = {4{`PHASE_RESET}};
      s_d.ref_div = `DIV_RESET;
      s_d.fb_div = `DIV_RESET;
      s_d.out_div = `DIV_RESET;
      s_d.ctrl = `CTRL_RESET;
      s_d.settle = LOCK_LOAD;
      s_d.win = WIN_LOAD;
    end
  end

  always_ff @(posedge CLK) begin
    s_q <= s_d;
  end

  assign link.wb_ack = s_q.ack;
  assign link.wb_dat_r = s_q.rdata;
  assign link.lock = s_q.locked;
  assign LOCKED = s_q.locked;
  assign REF_SOURCE = s_q.refsel_prev;
  assign PHASE_OFFSETS = s_q.phase;
  assign REF_DIVIDER = s_q.ref_div;
  assign FB_DIVIDER = s_q.fb_div;
  assign OUT_DIVIDER = s_q.out_div;

endmodule : pll_loop_end

/* File: pll_user_ctl.sv */
// Purpose: User-side controller: phase step sequences, reference choice, settings access, lock watch.
// Assumes: Same CLK as the loop end; software port answers reads one cycle later.
// Notes: Commands arriving while busy are dropped; poll STATUS busy first.
`timescale 1ns/1ps
`include "pll_params.svh"
module pll_user_ctl #(
  parameter int LOCK_CYCLES = `LOCK_CYCLES
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic [7:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA,
  output logic IRQ,
  pll_link_if.user link
);

  if (LOCK_CYCLES < 1 || LOCK_CYCLES > 65535) begin : g_chk_lock
    $error("LOCK_CYCLES outside 1..65535");
  end

  localparam logic [15:0] LOCK_LOAD = 16'(LOCK_CYCLES);

  pll_pkg::ctl_state_str_t c_q;
  pll_pkg::ctl_state_str_t c_d;
  logic idle;
  logic [3:0] events;
  logic [31:0] status;

  always_comb begin
    c_d = c_q;
    events = 4'h0;
    idle = c_q.state == pll_pkg::ST_IDLE;
    status = {16'h0000, c_q.bus_rdata, 5'h00, c_q.stable, link.lock, ~idle};

    case (c_q.state)
      pll_pkg::ST_IDLE: begin
        if (WR && ADDR == `REG_PHASE_CMD && WDATA[`CMD_COUNT_LSB +: 4] != 4'h0) begin
          c_d.sel = WDATA[`CMD_SEL_LSB +: 2]; // RULE_07
          c_d.dir = WDATA[`CMD_DIR_BIT]; // RULE_08
          c_d.count = WDATA[`CMD_COUNT_LSB +: 4];
          c_d.state = pll_pkg::ST_SETUP;
        end else if (WR && ADDR == `REG_CFG_CMD) begin
          // Settings go through the bridge's bus port
          c_d.cyc = 1'b1; // RULE_05
          c_d.we = ~WDATA[`CFG_READ_BIT];
          c_d.adr = WDATA[`CFG_ADDR_LSB +: 8];
          c_d.dat = WDATA[`CFG_DATA_LSB +: 8];
          c_d.state = pll_pkg::ST_BUS;
        end else if (WR && ADDR == `REG_REF_SEL) begin
          c_d.refsel = WDATA[0];
          c_d.stable = 1'b0;
          c_d.settle = LOCK_LOAD;
          c_d.state = pll_pkg::ST_SETTLE;
        end
      end
      pll_pkg::ST_SETUP: begin
        // Select and direction settle a cycle before the toggle
        c_d.state = pll_pkg::ST_TOGGLE; // RULE_10
      end
      pll_pkg::ST_TOGGLE: begin
        c_d.step = ~c_q.step; // RULE_09
        c_d.count = c_q.count - 4'h1;
        c_d.state = pll_pkg::ST_GAP;
      end
      pll_pkg::ST_GAP: begin
        // Held a cycle after the toggle as well
        if (c_q.count != 4'h0) begin
          c_d.state = pll_pkg::ST_TOGGLE; // RULE_10
        end else begin
          events[`INT_STEP_DONE] = 1'b1;
          c_d.stable = 1'b0; // RULE_02
          c_d.settle = LOCK_LOAD; // RULE_02
          c_d.state = pll_pkg::ST_SETTLE;
        end
      end
      pll_pkg::ST_BUS: begin
        if (link.wb_ack) begin
          c_d.cyc = 1'b0;
          c_d.bus_rdata = link.wb_dat_r;
          events[`INT_CFG_DONE] = 1'b1;
          if (c_q.we) begin
            c_d.stable = 1'b0; // RULE_06
            c_d.settle = LOCK_LOAD; // RULE_06
            c_d.state = pll_pkg::ST_SETTLE;
          end else begin
            c_d.state = pll_pkg::ST_IDLE;
          end
        end
      end
      pll_pkg::ST_SETTLE: begin
        // Clocks trusted only after the full lock time and a lock seen
        if (c_q.settle != 16'h0000) begin
          c_d.settle = c_q.settle - 16'h0001; // RULE_02 RULE_06
        end else if (link.lock) begin
          c_d.stable = 1'b1; // RULE_02 RULE_06
          events[`INT_STABLE] = 1'b1;
          c_d.state = pll_pkg::ST_IDLE;
        end
      end
      default: c_d.state = pll_pkg::ST_IDLE;
    endcase

    c_d.lock_prev = link.lock;
    if (c_q.lock_prev && !link.lock) begin
      events[`INT_LOCK_LOST] = 1'b1;
      c_d.stable = 1'b0;
    end

    // Set wins over a write-one clear in the same cycle
    if (WR && ADDR == `REG_INT_STATUS) begin
      c_d.int_st = c_q.int_st & ~WDATA[3:0];
    end
    c_d.int_st = c_d.int_st | events;
    if (WR && ADDR == `REG_INT_MASK) begin
      c_d.int_mask = WDATA[3:0];
    end
    c_d.irq = |(c_d.int_st & c_d.int_mask);

    c_d.rd = 32'h0000_0000;
    if (RD) begin
      case (ADDR)
        `REG_PHASE_CMD: c_d.rd = {20'h0_0000, c_q.count, 5'h00, c_q.dir, c_q.sel};
        `REG_REF_SEL: c_d.rd = {31'h0000_0000, c_q.refsel};
        `REG_CFG_CMD: c_d.rd = {15'h0000, ~c_q.we, c_q.adr, c_q.dat};
        `REG_STATUS: c_d.rd = status;
        `REG_INT_STATUS: c_d.rd = {28'h000_0000, c_q.int_st};
        `REG_INT_MASK: c_d.rd = {28'h000_0000, c_q.int_mask};
        default: c_d.rd = 32'h0000_0000;
      endcase
    end

    if (RST) begin
      c_d = '0;
      c_d.state = pll_pkg::ST_IDLE;
    end
  end

  always_ff @(posedge CLK) begin
    c_q <= c_d;
  end

  assign RDATA = c_q.rd;
  assign IRQ = c_q.irq;
  assign link.phase_output_select = c_q.sel;
  assign link.phase_step_direction = c_q.dir;
  assign link.phase_step_toggle = c_q.step;
  assign link.reference_source_selector = c_q.refsel;
  assign link.wb_cyc = c_q.cyc;
  assign link.wb_stb = c_q.cyc;
  assign link.wb_we = c_q.we;
  assign link.wb_adr = c_q.adr;
  assign link.wb_dat_w = c_q.dat;

endmodule : pll_user_ctl

/* File: pll_link_chk.sv */
// Purpose: Timing checks on the link between loop end and user controller
// Assumes: One clock, synchronous active-high reset
// Notes: Sees only link signals; loop settings are judged by the bench
`timescale 1ns/1ps
`include "pll_params.svh"
module pll_link_chk #(
  parameter int LOCK_CYCLES = `LOCK_CYCLES
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic [1:0] phase_output_select,
  input wire logic phase_step_direction,
  input wire logic phase_step_toggle,
  input wire logic reference_source_selector,
  input wire logic wb_cyc,
  input wire logic wb_stb,
  input wire logic wb_we,
  input wire logic [7:0] wb_adr,
  input wire logic [7:0] wb_dat_w,
  input wire logic [7:0] wb_dat_r,
  input wire logic wb_ack,
  input wire logic lock
);
  logic [15:0] quiet_q;
  logic sel_prev_q;
  // Cycles since the lock wait last restarted; steps on the feedback output are not visible here
  always_ff @(posedge CLK) begin
    sel_prev_q <= reference_source_selector;
    if (RST || (wb_ack && wb_we && wb_adr < 8'h04) || sel_prev_q != reference_source_selector) begin
      quiet_q <= 16'h0000;
    end else if (quiet_q != 16'hFFFF) begin
      quiet_q <= quiet_q + 16'h0001;
    end
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  sequence s_bus_open; $rose(wb_cyc); endsequence
  sequence s_bus_close; wb_ack ##1 !wb_cyc; endsequence
  sequence s_step; $changed(phase_step_toggle); endsequence
  // A sequence, not a property, so that it can be chained with a delay
  sequence s_steady; $stable(phase_output_select) && $stable(phase_step_direction); endsequence
  a_bus_ack_close: assert property (s_bus_open |=> s_bus_close) else $error("bus cycle not closed");
  a_ack_single: assert property (wb_ack |=> !wb_ack) else $error("ack longer than one cycle");
  a_cyc_stb_pair: assert property (wb_cyc == wb_stb) else $error("cyc and stb differ");
  a_bus_req_hold: assert property (wb_cyc && !wb_ack |=> $stable(wb_adr) && $stable(wb_we) && $stable(wb_dat_w))
    else $error("bus request changed before ack");
  a_write_data_zero: assert property (wb_ack && wb_we |-> wb_dat_r == 8'h00) else $error("write ack data");
  a_cfg_lock_drop: assert property (wb_ack && wb_we && wb_adr < 8'h04 |=> !lock [*2])
    else $error("lock kept after settings write");
  a_sel_lock_drop: assert property ($changed(reference_source_selector) |-> ##[1:3] !lock)
    else $error("lock kept after reference switch");
  a_lock_wait_min: assert property ($rose(lock) |-> quiet_q >= LOCK_CYCLES - 2)
    else $error("lock before lock time");
  a_step_spacing: assert property (s_step |=> !$changed(phase_step_toggle)) else $error("toggles too close");
  a_step_steady: assert property (s_step |-> s_steady ##1 s_steady)
    else $error("select or direction moved at a step");
endmodule : pll_link_chk

/* File: tb_pll_dynamic_phase_reconfig.sv */
// Purpose: Drives the controller's software port and judges both loop ends
// Assumes: Lock wait shortened to 20 cycles, 16-cycle lock window
// Notes: Feedback follows the chosen reference in place of the analog loop
`timescale 1ns/1ps
`include "pll_params.svh"
module tb_pll_dynamic_phase_reconfig;
  localparam int LOCK_N = 20;
  logic clk, rst, ref_a, ref_b, wr, rd, irq, locked, ref_source;
  logic [7:0] addr, ref_div, fb_div, out_div;
  logic [31:0] wdata, rdata, offsets, got, exp_off;
  int error_cnt;
  int samples_checked;
  pll_link_if link ();
  pll_loop_end #(.LOCK_CYCLES(LOCK_N), .WIN_CYCLES(16)) pll_loop_end_inst (.CLK(clk), .RST(rst),
    .LOOP_REFERENCE_IN_A(ref_a), .LOOP_REFERENCE_IN_B(ref_b), .LOOP_FEEDBACK_IN(ref_source ? ref_b : ref_a),
    .link(link.loop), .LOCKED(locked), .REF_SOURCE(ref_source), .PHASE_OFFSETS(offsets),
    .REF_DIVIDER(ref_div), .FB_DIVIDER(fb_div), .OUT_DIVIDER(out_div));
  pll_user_ctl #(.LOCK_CYCLES(LOCK_N)) pll_user_ctl_inst (.CLK(clk), .RST(rst), .ADDR(addr), .WDATA(wdata),
    .WR(wr), .RD(rd), .RDATA(rdata), .IRQ(irq), .link(link.user));
  pll_link_chk #(.LOCK_CYCLES(LOCK_N)) pll_link_chk_inst (.CLK(clk), .RST(rst),
    .phase_output_select(link.phase_output_select), .phase_step_direction(link.phase_step_direction),
    .phase_step_toggle(link.phase_step_toggle), .reference_source_selector(link.reference_source_selector),
    .wb_cyc(link.wb_cyc), .wb_stb(link.wb_stb), .wb_we(link.wb_we), .wb_adr(link.wb_adr),
    .wb_dat_w(link.wb_dat_w), .wb_dat_r(link.wb_dat_r), .wb_ack(link.wb_ack), .lock(link.lock));
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch at %0t: %s got %h want %h", $time, m, g, e);
    end
  endtask : chk
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    got = rdata;
  endtask : rd_reg
  // Bounded poll, so a stuck busy flag ends as a mismatch rather than a hang
  task automatic wait_idle();
    for (int n = 0; n < 300; n++) begin
      rd_reg(`REG_STATUS);
      if (got[0] === 1'b0) break;
    end
    chk({31'h0, got[0]}, 32'h0, "busy stuck");
  endtask : wait_idle
  task automatic wait_lock();
    for (int n = 0; n < 400 && locked !== 1'b1; n++) @(posedge clk);
    chk({31'h0, locked}, 32'h1, "no lock");
  endtask : wait_lock
  task automatic t_reset();
    chk(offsets, 32'h0, "reset offsets");
    chk({8'h0, ref_div, fb_div, out_div}, 32'h0001_0101, "reset dividers");
    chk({31'h0, locked}, 32'h0, "reset lock");
    rd_reg(8'h20);
    chk(got, 32'h0, "unmapped read");
    wait_lock();
  endtask : t_reset
  task automatic t_phase();
    for (int n = 3; n >= 0; n--) begin
      wr_reg(`REG_INT_STATUS, 32'h0000_000F);
      wr_reg(`REG_PHASE_CMD, {20'h0, 4'h3, 5'h0, 1'b1, n[1:0]});
      wait_idle();
      wr_reg(`REG_PHASE_CMD, {20'h0, 4'h1, 5'h0, 1'b0, n[1:0]});
      wait_idle();
      exp_off[8*n +: 8] = 8'h02;
      chk(offsets, exp_off, "offsets after steps");
      rd_reg(`REG_INT_STATUS);
      chk({29'h0, got[2:0]}, {29'h0, n == 0, 2'b01}, "step events");
    end
    wr_reg(`REG_PHASE_CMD, 32'h0000_0F05);
    wait_idle();
    wr_reg(`REG_PHASE_CMD, 32'h0000_0006);
    wait_idle();
    exp_off[15:8] = 8'h11;
    chk(offsets, exp_off, "count 15 and count 0");
    wait_lock();
  endtask : t_phase
  task automatic t_cfg();
    wr_reg(`REG_INT_STATUS, 32'h0000_000F);
    for (int a = 0; a < 3; a++) begin
      wr_reg(`REG_CFG_CMD, {16'h0, a[7:0], 8'h05 + a[7:0]});
      wait_idle();
    end
    chk({8'h0, ref_div, fb_div, out_div}, 32'h0005_0607, "dividers");
    rd_reg(`REG_INT_STATUS);
    chk({30'h0, got[2:1]}, 32'h3, "settings events");
    wr_reg(`REG_CFG_CMD, 32'h0001_0100);
    wait_idle();
    chk({24'h0, got[15:8]}, 32'h06, "settings read");
    wr_reg(`REG_CFG_CMD, 32'h0000_04AA);
    wait_idle();
    wr_reg(`REG_CFG_CMD, 32'h0001_0400);
    wait_idle();
    chk({24'h0, got[15:8]}, 32'h0, "unmapped setting");
    wr_reg(`REG_CFG_CMD, 32'h0000_0300);
    wait_idle();
    wr_reg(`REG_PHASE_CMD, 32'h0000_0105);
    wait_idle();
    chk(offsets, 32'h0, "static offsets");
    wr_reg(`REG_CFG_CMD, 32'h0000_0301);
    wait_idle();
    wait_lock();
  endtask : t_cfg
  task automatic t_ref(input logic s);
    wr_reg(`REG_INT_STATUS, 32'h0000_000F);
    wr_reg(`REG_REF_SEL, {31'h0, s});
    wait_idle();
    chk({31'h0, got[2]}, 32'h1, "stable after switch");
    chk({31'h0, ref_source}, {31'h0, s}, "reference source");
    rd_reg(`REG_INT_STATUS);
    chk({31'h0, got[2]}, 32'h1, "switch lock event");
    chk({31'h0, got[3]}, 32'h1, "switch stable event");
    wait_lock();
  endtask : t_ref
  task automatic t_irq();
    wr_reg(`REG_INT_MASK, 32'h0);
    wr_reg(`REG_INT_STATUS, 32'h0000_000F);
    wr_reg(`REG_PHASE_CMD, 32'h0000_0105);
    wait_idle();
    chk(offsets, 32'h0000_0100, "step after static mode");
    chk({31'h0, irq}, 32'h0, "masked irq");
    wr_reg(`REG_INT_MASK, 32'h0000_0001);
    repeat (2) @(posedge clk);
    #1;
    chk({31'h0, irq}, 32'h1, "unmasked irq");
    wr_reg(`REG_INT_STATUS, 32'h0000_0001);
    repeat (2) @(posedge clk);
    #1;
    chk({31'h0, irq}, 32'h0, "cleared irq");
  endtask : t_irq
  task automatic test_done();
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : test_done
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Reference sources slower than a quarter of CLK, unrelated in phase
  initial begin
    ref_a = 1'b0;
    forever #100 ref_a = ~ref_a;
  end
  initial begin
    ref_b = 1'b0;
    forever #140 ref_b = ~ref_b;
  end
  initial begin
    rst = 1'b1;
    addr = 8'h00;
    wdata = 32'h0;
    wr = 1'b0;
    rd = 1'b0;
    exp_off = 32'h0;
    error_cnt = 0;
    samples_checked = 0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    t_reset();
    t_phase();
    t_cfg();
    t_ref(1'b1);
    t_ref(1'b0);
    t_irq();
    test_done();
  end
  initial begin
    repeat (60000) @(posedge clk);
    error_cnt++;
    $display("mismatch at %0t: watchdog expired", $time);
    test_done();
  end
endmodule : tb_pll_dynamic_phase_reconfig
